// ---- design/dtpwm_pkg.sv ----
// Constants, register map and types of the down timer with PWM output
`default_nettype none
package dtpwm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_COUNT_LOW   = 6'h10;
	localparam logic [5:0] IDX_CONTROL_ONE = 6'h11;
	localparam logic [5:0] IDX_CONTROL_TWO = 6'h12;
	localparam logic [5:0] IDX_DUTY_LOW    = 6'h13;
	localparam logic [5:0] IDX_RELOAD_HIGH = 6'h16;
	localparam int         ADDR_W          = 8;
	localparam int         CNT_W           = 10;
	localparam int         PS_W            = 8;
	// Field positions of timer_control_one
	localparam int C1_RUN        = 0;
	localparam int C1_RELOAD     = 1;
	localparam int C1_ONE_SHOT   = 2;
	localparam int C1_HIGH_CLOCK = 3;
	localparam int C1_ACT_LOW    = 6;
	localparam int C1_PIN_EN     = 7;
	// Field positions of timer_control_two
	localparam int C2_SEL_LSB    = 0;
	localparam int C2_SEL_MSB    = 2;
	localparam int C2_PS_DIS_N   = 3;
	localparam int C2_EDGE       = 4;
	localparam int C2_EXT        = 5;
	localparam int C2_HALF       = 6;
	// Field positions of timer_reload_high
	localparam int RH_DUTY_LSB   = 0;
	localparam int RH_DUTY_MSB   = 1;
	localparam int RH_RLD_LSB    = 4;
	localparam int RH_RLD_MSB    = 5;
	// Reset values
	localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
	localparam logic [7:0] CONTROL_TWO_RST = 8'h3f;
	localparam logic [7:0] RELOAD_HIGH_RST = 8'h00;
	localparam logic [7:0] DUTY_LOW_RST    = 8'h00;
	localparam logic [7:0] READ_ZERO       = 8'h00;
	localparam logic [7:0] C1_READ_MASK    = 8'hcf;
	localparam logic [7:0] C2_READ_MASK    = 8'h3f;
	localparam logic [7:0] RH_READ_MASK    = 8'h33;
	localparam logic [CNT_W-1:0] CNT_ALL_ONES = 10'h3ff;
	localparam logic [CNT_W-1:0] CNT_ZERO     = 10'h000;
	localparam logic [CNT_W-1:0] CNT_ONE      = 10'h001;
	localparam logic [PS_W-1:0]  PS_ZERO      = 8'h00;
	localparam logic [PS_W-1:0]  PS_ONE       = 8'h01;

	// Timer sequencing state, one-hot
	typedef enum logic [2:0] {
		DTPWM_IDLE = 3'b001,
		DTPWM_RUN  = 3'b010,
		DTPWM_DONE = 3'b100
	} dtpwm_state_t;

	// Prescaler mask for code n: ratio 2^(n+1), mask holds n+1 low ones
	function automatic logic [PS_W-1:0] dtpwm_ps_mask(input logic [2:0] code);
		logic [PS_W-1:0] m;
		m = PS_ZERO;
		for (int i = 0; i < PS_W; i++) begin
			if (i <= int'(code))
				m[i] = 1'b1;
		end
		return m;
	endfunction
endpackage
`default_nettype wire

// ---- design/dtpwm_tick_if.sv ----
// Carrier between the timer core and its clock-source and prescaler stage
`timescale 1ns/1ps
`default_nettype none
interface dtpwm_tick_if;
	logic       high_clock;
	logic       ext_select;
	logic       edge_fall;
	logic       ps_disable_n;
	logic [2:0] ps_select;
	logic       tick;
	modport core (output high_clock, ext_select, edge_fall, ps_disable_n, ps_select,
		input tick);
	modport stage (input high_clock, ext_select, edge_fall, ps_disable_n, ps_select,
		output tick);
endinterface
`default_nettype wire

// ---- design/dtpwm_tick.sv ----
// Clock-source selection, external edge detection and prescaler
`timescale 1ns/1ps
`default_nettype none
module dtpwm_tick (
	input  wire logic     clk,
	input  wire logic     rst_n,
	input  wire logic     instr_clk_en,
	input  wire logic     high_osc_en,
	input  wire logic     external_clock_pin,
	dtpwm_tick_if.stage   cfg
);
	import dtpwm_pkg::*;

	logic            pin_reg;
	logic            pin_next;
	logic [PS_W-1:0] ps_reg;
	logic [PS_W-1:0] ps_next;
	logic            src_event;
	logic            tick_out;
	logic [PS_W-1:0] mask;

	// Source pick: high clock overrides the external select
	always_comb begin
		pin_next = external_clock_pin;
		mask = dtpwm_ps_mask(cfg.ps_select);
		if (cfg.high_clock)
			src_event = high_osc_en;
		else if (cfg.ext_select) begin
			if (cfg.edge_fall)
				src_event = pin_reg & ~external_clock_pin;
			else
				src_event = ~pin_reg & external_clock_pin;
		end else
			src_event = instr_clk_en;
		ps_next = ps_reg;
		tick_out = 1'b0;
		// Bypass passes every event; the counter is kept at zero so
		// re-enabling starts a clean ratio
		if (cfg.ps_disable_n) begin
			ps_next = PS_ZERO;
			tick_out = src_event;
		end else if (src_event) begin
			if ((ps_reg & mask) == mask) begin
				ps_next = PS_ZERO;
				tick_out = 1'b1;
			end else
				ps_next = ps_reg + PS_ONE;
		end
	end

	// Registers of the stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_reg <= 1'b0;
			ps_reg  <= PS_ZERO;
		end else begin
			pin_reg <= pin_next;
			ps_reg  <= ps_next;
		end
	end

	assign cfg.tick = tick_out;
endmodule
`default_nettype wire

// ---- design/dtpwm_timer.sv ----
// 10-bit down timer with reload, one-shot and PWM output on a shared pin
// Contract
// - Reading count low returns bits 7:0 of the live counter.
// - Writing count low loads all ten bits from reload high field and reload byte.
// - Free-run without reload wraps from zero to all ones.
// - Free-run with reload reloads the stored value after zero.
// - One-shot counts once to zero and stops, reload ignored.
// - High-clock select clocks timer and PWM from the high oscillator.
// - With high-clock clear, the clock-source select bit picks the clock.
// - Polarity bit set makes PWM active low, clear active high.
// - Pin enable drives PWM on the shared pin, else pin stays GPIO.
// - Prescaler codes 000, 001, 010 divide by 2, 4, 8.
// - Clock-source select set counts the external pin, else internal clocks.
// - Edge select set counts falling pin edges, clear rising edges.
// - High clock with half-step bit stretches the duty by half a timer clock.
`timescale 1ns/1ps
`default_nettype none
module dtpwm_timer (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic [dtpwm_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [31:0]                   avs_writedata,
	input  wire logic [3:0]                    avs_byteenable,
	output logic [31:0]                        avs_readdata,
	output logic                               avs_waitrequest,
	input  wire logic                          instr_clk_en,
	input  wire logic                          high_osc_en,
	input  wire logic                          external_clock_pin,
	input  wire logic                          gpio_out,
	input  wire logic                          gpio_oe_n,
	output logic                               shared_port_pin_out,
	output logic                               shared_port_pin_oe_n
);
	import dtpwm_pkg::*;

	dtpwm_tick_if tick_if ();

	// Counter word from the reload high field and a low byte; shared by load and reload
	function automatic logic [CNT_W-1:0] cnt_word(input logic [7:0] hi_reg, input logic [7:0] lo);
		return {hi_reg[RH_RLD_MSB:RH_RLD_LSB], lo};
	endfunction

	// Register file; the half-step bit lives in control two but never reads back
	logic [7:0]       ctl1_reg;
	logic [7:0]       ctl1_next;
	logic [7:0]       ctl2_reg;
	logic [7:0]       ctl2_next;
	logic [7:0]       rh_reg;
	logic [7:0]       rh_next;
	logic [7:0]       rl_reg;
	logic [7:0]       rl_next;
	logic [7:0]       duty_reg;
	logic [7:0]       duty_next;
	// Live counter and its sequencing state
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	dtpwm_state_t     state_reg;
	dtpwm_state_t     state_next;
	// Bus answer: one-cycle acknowledge and registered read data
	logic             ack_reg;
	logic             ack_next;
	logic [31:0]      rdata_reg;
	logic [31:0]      rdata_next;
	// Half-step stretch: clk cycles since the last tick, the last interval,
	// and the remaining stretch; saturate so a slow source cannot wrap them
	logic [PS_W-1:0]  gap_reg;
	logic [PS_W-1:0]  gap_next;
	logic [PS_W-1:0]  period_reg;
	logic [PS_W-1:0]  period_next;
	logic [PS_W-1:0]  ext_reg;
	logic [PS_W-1:0]  ext_next;
	// PWM level and the registered pin drive
	logic             pwm_reg;
	logic             pwm_next;
	logic             pin_reg;
	logic             pin_next;
	logic             oe_n_reg;
	logic             oe_n_next;
	// Decoded bus strobes
	logic [5:0]       index;
	logic             wr_take;
	logic             rd_take;
	logic             load_cnt;
	logic [CNT_W-1:0] duty_val;
	logic             active_raw;

	// Configuration carried to the source and prescaler stage; the stage
	// keeps no copy, so a control write retimes the very next event
	assign tick_if.high_clock   = ctl1_reg[C1_HIGH_CLOCK];
	assign tick_if.ext_select   = ctl2_reg[C2_EXT];
	assign tick_if.edge_fall    = ctl2_reg[C2_EDGE];
	assign tick_if.ps_disable_n = ctl2_reg[C2_PS_DIS_N];
	assign tick_if.ps_select    = ctl2_reg[C2_SEL_MSB:C2_SEL_LSB];

	dtpwm_tick u_tick (
		.clk                (clk),
		.rst_n              (rst_n),
		.instr_clk_en       (instr_clk_en),
		.high_osc_en        (high_osc_en),
		.external_clock_pin (external_clock_pin),
		.cfg                (tick_if)
	);

	// Bus decode: one wait cycle, answer on the second edge of a request.
	// A write acts at the first edge; the master still holds it one more
	// cycle, and ack_reg keeps that second cycle from acting twice
	assign index           = avs_address[ADDR_W-1:2];
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign wr_take         = avs_write & ~ack_reg & avs_byteenable[0];
	assign rd_take         = avs_read & ~ack_reg;
	assign load_cnt        = wr_take && (index == IDX_COUNT_LOW);
	assign avs_readdata    = rdata_reg;

	// Register file next values; reserved bits are masked on the way in,
	// so reads need no second mask except for the write-only half-step bit
	always_comb begin
		ctl1_next  = ctl1_reg;
		ctl2_next  = ctl2_reg;
		rh_next    = rh_reg;
		rl_next    = rl_reg;
		duty_next  = duty_reg;
		ack_next   = (avs_read | avs_write) & ~ack_reg;
		rdata_next = rdata_reg;
		if (wr_take) begin
			case (index)
				IDX_COUNT_LOW: begin
					rl_next = avs_writedata[7:0];
				end
				IDX_CONTROL_ONE: begin
					ctl1_next = avs_writedata[7:0] & C1_READ_MASK;
				end
				IDX_CONTROL_TWO: begin
					ctl2_next = avs_writedata[7:0] & C2_READ_MASK;
					ctl2_next[C2_HALF] = avs_writedata[C2_HALF];
				end
				IDX_DUTY_LOW: begin
					duty_next = avs_writedata[7:0];
				end
				IDX_RELOAD_HIGH: begin
					rh_next = avs_writedata[7:0] & RH_READ_MASK;
				end
				default: begin
				end
			endcase
		end
		// Read data is latched once per request and then held for the master
		if (rd_take) begin
			rdata_next = 32'h0000_0000;
			case (index)
				IDX_COUNT_LOW: begin
					rdata_next[7:0] = cnt_reg[7:0];
				end
				IDX_CONTROL_ONE: begin
					rdata_next[7:0] = ctl1_reg;
				end
				IDX_CONTROL_TWO: begin
					// Half-step bit is write-only and reads zero
					rdata_next[7:0] = ctl2_reg & C2_READ_MASK;
				end
				IDX_RELOAD_HIGH: begin
					rdata_next[7:0] = rh_reg;
				end
				default: begin
					rdata_next[7:0] = READ_ZERO;
				end
			endcase
		end
	end

	// Counter and sequencing; a count-low write wins over a tick.
	// A one-shot run parks in the done state with the counter at zero;
	// only a fresh load or clearing one-shot lets it run again.
	// Entering the run state costs one cycle, so a tick in that cycle is lost
	always_comb begin
		cnt_next   = cnt_reg;
		state_next = state_reg;
		if (load_cnt) begin
			cnt_next = cnt_word(rh_reg, avs_writedata[7:0]);
			state_next = ctl1_reg[C1_RUN] ? DTPWM_RUN : DTPWM_IDLE;
		end else begin
			case (state_reg)
				DTPWM_IDLE: begin
					if (ctl1_reg[C1_RUN])
						state_next = DTPWM_RUN;
				end
				DTPWM_RUN: begin
					if (!ctl1_reg[C1_RUN])
						state_next = DTPWM_IDLE;
					else if (tick_if.tick) begin
						if (cnt_reg != CNT_ZERO)
							cnt_next = cnt_reg - CNT_ONE;
						else if (ctl1_reg[C1_ONE_SHOT])
							state_next = DTPWM_DONE;
						else if (ctl1_reg[C1_RELOAD])
							cnt_next = cnt_word(rh_reg, rl_reg);
						else
							cnt_next = CNT_ALL_ONES;
					end
				end
				DTPWM_DONE: begin
					// Stays stopped until software loads a new count or clears one-shot with run set
					if (!ctl1_reg[C1_ONE_SHOT] && ctl1_reg[C1_RUN])
						state_next = DTPWM_RUN;
				end
				default: begin
					state_next = DTPWM_IDLE;
				end
			endcase
		end
	end

	// PWM: active while count is below duty; half-step stretch measured in
	// clk cycles of the last tick interval, so it is exact only to a cycle
	assign duty_val   = {rh_reg[RH_DUTY_MSB:RH_DUTY_LSB], duty_reg};
	assign active_raw = (cnt_reg < duty_val);
	always_comb begin
		gap_next    = gap_reg;
		period_next = period_reg;
		ext_next    = ext_reg;
		pwm_next    = active_raw;
		if (tick_if.tick) begin
			gap_next    = PS_ZERO;
			period_next = gap_reg;
		end else if (gap_reg != {PS_W{1'b1}})
			gap_next = gap_reg + PS_ONE;
		if (ctl1_reg[C1_HIGH_CLOCK] && ctl2_reg[C2_HALF]) begin
			if (pwm_reg && !active_raw && ext_reg == PS_ZERO && !tick_if.tick)
				ext_next = period_reg >> 1;
			if (ext_reg != PS_ZERO) begin
				ext_next = ext_reg - PS_ONE;
				pwm_next = 1'b1;
			end
		end else
			ext_next = PS_ZERO;
		// Pin mux: port logic owns the pin unless PWM is enabled; the
		// polarity flip is applied last so the stretch stays level-neutral
		pin_next  = gpio_out;
		oe_n_next = gpio_oe_n;
		if (ctl1_reg[C1_PIN_EN]) begin
			pin_next  = pwm_next ^ ctl1_reg[C1_ACT_LOW];
			oe_n_next = 1'b0;
		end
	end

	// All timer state outside the tick stage; reset parks the pin released so the pad
	// pull-up sets its level until software claims it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl1_reg   <= CONTROL_ONE_RST;
			ctl2_reg   <= CONTROL_TWO_RST;
			rh_reg     <= RELOAD_HIGH_RST;
			rl_reg     <= READ_ZERO;
			duty_reg   <= DUTY_LOW_RST;
			cnt_reg    <= CNT_ZERO;
			state_reg  <= DTPWM_IDLE;
			ack_reg    <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			gap_reg    <= PS_ZERO;
			period_reg <= PS_ZERO;
			ext_reg    <= PS_ZERO;
			pwm_reg    <= 1'b0;
			pin_reg    <= 1'b0;
			oe_n_reg   <= 1'b1;
		end else begin
			ctl1_reg   <= ctl1_next;
			ctl2_reg   <= ctl2_next;
			rh_reg     <= rh_next;
			rl_reg     <= rl_next;
			duty_reg   <= duty_next;
			cnt_reg    <= cnt_next;
			state_reg  <= state_next;
			ack_reg    <= ack_next;
			rdata_reg  <= rdata_next;
			gap_reg    <= gap_next;
			period_reg <= period_next;
			ext_reg    <= ext_next;
			pwm_reg    <= pwm_next;
			pin_reg    <= pin_next;
			oe_n_reg   <= oe_n_next;
		end
	end

	// Pin outputs come straight from flip-flops
	assign shared_port_pin_out  = pin_reg;
	assign shared_port_pin_oe_n = oe_n_reg;
endmodule
`default_nettype wire

// ---- testbench/dtpwm_timer_monitor.sv ----
// Port checker of the down timer: bus handshake, read data and pin routing
`timescale 1ns/1ps
`default_nettype none
module dtpwm_timer_monitor (
	input wire logic                         clk,
	input wire logic                         rst_n,
	input wire logic [dtpwm_pkg::ADDR_W-1:0] avs_address,
	input wire logic                         avs_read,
	input wire logic                         avs_write,
	input wire logic [31:0]                  avs_writedata,
	input wire logic [3:0]                   avs_byteenable,
	input wire logic [31:0]                  avs_readdata,
	input wire logic                         avs_waitrequest,
	input wire logic                         gpio_out,
	input wire logic                         gpio_oe_n,
	input wire logic                         shared_port_pin_out,
	input wire logic                         shared_port_pin_oe_n
);
	import dtpwm_pkg::*;
	logic pen_reg;
	logic pen_next;
	logic rd_done;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Shadow of the pin enable; lags the device by one edge, so writes in flight are excluded
	assign rd_done = avs_read && !avs_waitrequest;
	always_comb begin
		pen_next = pen_reg;
		if (avs_write && !avs_waitrequest && avs_byteenable[0]
			&& avs_address[7:2] == IDX_CONTROL_ONE)
			pen_next = avs_writedata[C1_PIN_EN];
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pen_reg <= 1'b0;
		else
			pen_reg <= pen_next;
	end
	wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low in first request cycle");
	wait_end_a: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest high for two cycles");
	wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	rdata_upper_a: assert property (avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without read");
	ctl1_spare_a: assert property (rd_done && avs_address[7:2] == IDX_CONTROL_ONE
		|-> avs_readdata[5:4] == 2'b00) else $error("control one spare bits set");
	ctl2_spare_a: assert property (rd_done && avs_address[7:2] == IDX_CONTROL_TWO
		|-> avs_readdata[7:6] == 2'b00) else $error("control two write-only bits read");
	gpio_pass_a: assert property (!pen_reg && !avs_write |=>
		shared_port_pin_out == $past(gpio_out) && shared_port_pin_oe_n == $past(gpio_oe_n))
		else $error("pin not following port logic");
	pin_drive_a: assert property (pen_reg && !avs_write |=> !shared_port_pin_oe_n)
		else $error("pin not driven with output enabled");
endmodule
bind dtpwm_timer dtpwm_timer_monitor mon (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
	.shared_port_pin_out(shared_port_pin_out), .shared_port_pin_oe_n(shared_port_pin_oe_n));
`default_nettype wire

// ---- testbench/dtpwm_far_end.sv ----
// Far-side model: external clock source and the pad of the shared pin
`timescale 1ns/1ps
`default_nettype none
module dtpwm_far_end (
	input  wire logic clk,
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	output logic      ext_clk,
	output logic      pin_level
);
	// Pad has a pull-up, so a released pin reads high
	assign pin_level = pin_oe_n ? 1'b1 : pin_out;
	initial ext_clk = 1'b0;
	// Clock stands low between bursts; each level lasts two cycles
	task automatic burst(input int n);
		repeat (n) begin
			@(posedge clk);
			ext_clk <= 1'b1;
			@(posedge clk);
			@(posedge clk);
			ext_clk <= 1'b0;
			@(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// ---- testbench/tb_dtpwm_timer.sv ----
// Testbench of the down timer: register accesses, count modes, clocks, pin
`timescale 1ns/1ps
`default_nettype none
module tb_dtpwm_timer;
	import dtpwm_pkg::*;
	logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  be;
	logic        instr_clk_en, high_osc_en, ext_clk, gpio_out, gpio_oe_n;
	logic        pin_out, pin_oe_n, far_pin;
	int          fail_count, n_tests;
	dtpwm_timer DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.instr_clk_en(instr_clk_en), .high_osc_en(high_osc_en), .external_clock_pin(ext_clk),
		.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .shared_port_pin_out(pin_out),
		.shared_port_pin_oe_n(pin_oe_n));
	dtpwm_far_end far (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_clk(ext_clk),
		.pin_level(far_pin));
	// Clock generation
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus cycle; held until waitrequest is sampled low, bounded wait
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int k;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h000000, d};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			fail_count++;
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		check(q, e);
	endtask
	// One-cycle source events, one every two cycles
	task automatic pulse(input int n, input logic hi);
		repeat (n) begin
			@(posedge clk);
			if (hi)
				high_osc_en <= 1'b1;
			else
				instr_clk_en <= 1'b1;
			@(posedge clk);
			high_osc_en <= 1'b0;
			instr_clk_en <= 1'b0;
		end
	endtask
	task automatic pin(input logic o, input logic e);
		repeat (3) @(posedge clk);
		check({6'h00, pin_out, pin_oe_n}, {6'h00, o, e});
	endtask
	// Main sequence
	initial begin
		{rst_n, avs_read, avs_write, instr_clk_en, high_osc_en, gpio_out} = 6'h00;
		{avs_address, avs_writedata, fail_count, n_tests} = '0;
		be = 4'hf;
		gpio_oe_n = 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h44, 8'h00);
		rd(8'h48, 8'h3f);
		rd(8'h58, 8'h00);
		wr(8'h58, 8'h30);
		wr(8'h40, 8'h05);
		pulse(3, 1'b0);
		be <= 4'h0;
		wr(8'h40, 8'h77);
		be <= 4'hf;
		wr(8'h7c, 8'hff);
		rd(8'h40, 8'h05);
		wr(8'h48, 8'h08);
		wr(8'h44, 8'h01);
		pulse(3, 1'b0);
		pulse(2, 1'b1);
		rd(8'h40, 8'h02);
		wr(8'h58, 8'h00);
		wr(8'h40, 8'h01);
		pulse(3, 1'b0);
		rd(8'h40, 8'hfe);
		wr(8'h44, 8'h03);
		wr(8'h40, 8'h02);
		pulse(4, 1'b0);
		rd(8'h40, 8'h01);
		wr(8'h44, 8'h07);
		wr(8'h40, 8'h02);
		pulse(5, 1'b0);
		rd(8'h40, 8'h00);
		wr(8'h44, 8'h09); // Prescaler left bypassed under the high clock
		wr(8'h40, 8'h10);
		pulse(2, 1'b0);
		pulse(3, 1'b1);
		rd(8'h40, 8'h0d);
		wr(8'h44, 8'h01);
		wr(8'h48, 8'h38);
		wr(8'h40, 8'h10);
		pulse(2, 1'b0);
		far.burst(3);
		rd(8'h40, 8'h0d);
		wr(8'h48, 8'h28);
		wr(8'h40, 8'h10);
		far.burst(2);
		rd(8'h40, 8'h0e);
		// Three full prescaler periods give three counts whatever the phase
		for (int c = 0; c < 8; c++) begin
			wr(8'h48, 8'(c));
			wr(8'h40, 8'h10);
			pulse(3 << (c + 1), 1'b0);
			rd(8'h40, 8'h0d);
		end
		wr(8'h44, 8'h00);
		wr(8'h4c, 8'h80);
		wr(8'h40, 8'h10);
		pin(1'b0, 1'b1);
		check({7'h00, far_pin}, 8'h01);
		wr(8'h44, 8'h80);
		pin(1'b1, 1'b0);
		wr(8'h44, 8'hc0);
		pin(1'b0, 1'b0);
		wr(8'h40, 8'h90);
		pin(1'b1, 1'b0);
		wr(8'h44, 8'h00);
		@(posedge clk);
		gpio_out <= 1'b1;
		gpio_oe_n <= 1'b0;
		pin(1'b1, 1'b0);
		summarize();
	end
endmodule
`default_nettype wire
